// >>> bench/low_voltage_reset_flag_top_tb.sv
// self-checking testbench for the low-voltage reset and reset flag block
// assumes the design's own assertions run alongside; ticks of the slow clock every 5 cycles
`timescale 1ns/100ps

module low_voltage_reset_flag_top_tb;
  logic                    clock;
  logic                    resetn;
  low_voltage_reset_flag_pkg::low_voltage_reset_flag_bus_req_t bus_req;
  logic [7:0]              bus_rdata;
  logic                    lirc_tick;
  logic                    low_voltage_detect;
  logic                    power_down;
  logic                    watchdog_timeout;
  logic                    watchdog_ctrl_fault;
  logic                    halt_entry;
  logic                    watchdog_clear;
  logic                    chip_reset;
  logic                    pc_sp_clear;
  low_voltage_reset_flag_pkg::low_voltage_reset_flag_por_fx_t  por_effects;
  logic                    watchdog_run;
  logic                    idle_sysclk_keepalive;
  logic [7:0]              level_code;
  logic                    irq;
  logic [2:0]              tick_cnt;
  logic [7:0]              rv;
  int                      fail_count;
  int                      comparisons;
  int                      n;

  low_voltage_reset_flag_top low_voltage_reset_flag_top_i (
    .clock                 (clock),
    .resetn                (resetn),
    .bus_req               (bus_req),
    .bus_rdata             (bus_rdata),
    .lirc_tick             (lirc_tick),
    .low_voltage_detect    (low_voltage_detect),
    .power_down            (power_down),
    .watchdog_timeout      (watchdog_timeout),
    .watchdog_ctrl_fault   (watchdog_ctrl_fault),
    .halt_entry            (halt_entry),
    .watchdog_clear        (watchdog_clear),
    .chip_reset            (chip_reset),
    .pc_sp_clear           (pc_sp_clear),
    .por_effects           (por_effects),
    .watchdog_run          (watchdog_run),
    .idle_sysclk_keepalive (idle_sysclk_keepalive),
    .level_code            (level_code),
    .irq                   (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial clock = 1'b0;
  always #10 clock = ~clock;

  // slow oscillator stand-in: one pulse every fifth cycle
  always @(posedge clock) begin
    tick_cnt  <= (tick_cnt == 3'h4) ? 3'h0 : tick_cnt + 3'h1;
    lirc_tick <= (tick_cnt == 3'h4);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus_req <= '0;
    #1;
    d = bus_rdata;
  endtask : rd_reg

  // counts cycles until chip_reset shows, bounded
  task automatic wait_rst(output int cyc);
    cyc = 0;
    while (chip_reset !== 1'b1 && cyc < 100) begin
      @(posedge clock);
      #1;
      cyc++;
    end
  endtask : wait_rst

  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_power_on;
    resetn <= 1'b1;
    #1;
    check({2'h0, por_effects}, 8'h3F);
    check(level_code, 8'h55);
    check({7'h0, por_effects.int_disable}, 8'h01);
    @(posedge clock);
    #1;
    check({2'h0, por_effects}, 8'h00);
    check({7'h0, watchdog_run}, 8'h00);
    @(posedge clock);
    #1;
    check({7'h0, watchdog_run}, 8'h01);
    rd_reg(low_voltage_reset_flag_pkg::OFF_LEVEL_SEL, rv);
    check(rv, 8'h55);
    rd_reg(low_voltage_reset_flag_pkg::OFF_STATUS, rv);
    check(rv, 8'h00);
    rd_reg(low_voltage_reset_flag_pkg::OFF_CTRL, rv);
    check(rv, 8'h00);
    $display("test power_on done");
  endtask : test_power_on

  task automatic test_valid_codes;
    logic [7:0] codes [4];
    codes = '{8'h55, 8'h33, 8'h99, 8'hAA};
    foreach (codes[i]) begin
      wr_reg(low_voltage_reset_flag_pkg::OFF_LEVEL_SEL, codes[i]);
      rd_reg(low_voltage_reset_flag_pkg::OFF_LEVEL_SEL, rv);
      check(rv, codes[i]);
      repeat (20) @(posedge clock);
      #1;
      check({7'h0, chip_reset}, 8'h00);
    end
    wr_reg(low_voltage_reset_flag_pkg::OFF_CTRL, 8'hFF);
    rd_reg(low_voltage_reset_flag_pkg::OFF_CTRL, rv);
    check(rv, 8'h80);
    check({7'h0, idle_sysclk_keepalive}, 8'h01);
    wr_reg(3'h5, 8'hFF);
    rd_reg(3'h5, rv);
    check(rv, 8'h00);
    $display("test valid_codes done");
  endtask : test_valid_codes

  task automatic test_bad_code;
    wr_reg(low_voltage_reset_flag_pkg::OFF_IRQ_MASK, 8'h0F);
    wr_reg(low_voltage_reset_flag_pkg::OFF_LEVEL_SEL, 8'h5A);
    wait_rst(n);
    check({7'h0, (n >= 10 && n <= 25)}, 8'h01);
    repeat (2) @(posedge clock);
    #1;
    check(level_code, 8'h55);
    check({7'h0, irq}, 8'h01);
    rd_reg(low_voltage_reset_flag_pkg::OFF_CTRL, rv);
    check(rv & 8'h07, 8'h02);
    wr_reg(low_voltage_reset_flag_pkg::OFF_CTRL, 8'h80);
    rd_reg(low_voltage_reset_flag_pkg::OFF_CTRL, rv);
    check(rv, 8'h80);
    $display("test bad_code done");
  endtask : test_bad_code

  task automatic test_low_voltage;
    wr_reg(low_voltage_reset_flag_pkg::OFF_LEVEL_SEL, 8'h33);
    @(posedge clock);
    halt_entry <= 1'b1;
    @(posedge clock);
    halt_entry <= 1'b0;
    low_voltage_detect <= 1'b1;
    wait_rst(n);
    check({7'h0, (n >= 10 && n <= 30)}, 8'h01);
    @(posedge clock);
    low_voltage_detect <= 1'b0;
    repeat (20) @(posedge clock);
    #1;
    check(level_code, 8'h33);
    rd_reg(low_voltage_reset_flag_pkg::OFF_CTRL, rv);
    check(rv & 8'h07, 8'h04);
    rd_reg(low_voltage_reset_flag_pkg::OFF_STATUS, rv);
    check(rv, 8'h01);
    wr_reg(low_voltage_reset_flag_pkg::OFF_CTRL, 8'h00);
    rd_reg(low_voltage_reset_flag_pkg::OFF_CTRL, rv);
    check(rv, 8'h00);
    // supply low while powered down must not reset
    @(posedge clock);
    power_down         <= 1'b1;
    low_voltage_detect <= 1'b1;
    wait_rst(n);
    check({7'h0, chip_reset}, 8'h00);
    @(posedge clock);
    low_voltage_detect <= 1'b0;
    repeat (10) @(posedge clock);
    power_down <= 1'b0;
    $display("test low_voltage done");
  endtask : test_low_voltage

  task automatic test_watchdog;
    @(posedge clock);
    watchdog_clear <= 1'b1;
    @(posedge clock);
    watchdog_clear   <= 1'b0;
    watchdog_timeout <= 1'b1;
    @(posedge clock);
    watchdog_timeout <= 1'b0;
    wait_rst(n);
    check({7'h0, (n >= 10 && n <= 25)}, 8'h01);
    repeat (2) @(posedge clock);
    rd_reg(low_voltage_reset_flag_pkg::OFF_STATUS, rv);
    check(rv, 8'h02);
    @(posedge clock);
    power_down       <= 1'b1;
    watchdog_timeout <= 1'b1;
    @(posedge clock);
    watchdog_timeout <= 1'b0;
    #1;
    check({7'h0, pc_sp_clear}, 8'h01);
    wait_rst(n);
    check({7'h0, chip_reset}, 8'h00);
    rd_reg(low_voltage_reset_flag_pkg::OFF_STATUS, rv);
    check(rv, 8'h03);
    check(level_code, 8'h33);
    @(posedge clock);
    power_down <= 1'b0;
    $display("test watchdog done");
  endtask : test_watchdog

  task automatic test_interrupts;
    @(posedge clock);
    watchdog_ctrl_fault <= 1'b1;
    @(posedge clock);
    watchdog_ctrl_fault <= 1'b0;
    rd_reg(low_voltage_reset_flag_pkg::OFF_CTRL, rv);
    check(rv, 8'h01);
    rd_reg(low_voltage_reset_flag_pkg::OFF_IRQ_STATUS, rv);
    check(rv, 8'h0F);
    wr_reg(low_voltage_reset_flag_pkg::OFF_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clock);
    #1;
    check({7'h0, irq}, 8'h00);
    wr_reg(low_voltage_reset_flag_pkg::OFF_IRQ_MASK, 8'h08);
    wr_reg(low_voltage_reset_flag_pkg::OFF_IRQ_STATUS, 8'h07);
    rd_reg(low_voltage_reset_flag_pkg::OFF_IRQ_STATUS, rv);
    check(rv, 8'h08);
    check({7'h0, irq}, 8'h01);
    wr_reg(low_voltage_reset_flag_pkg::OFF_IRQ_STATUS, 8'h08);
    repeat (2) @(posedge clock);
    #1;
    check({7'h0, irq}, 8'h00);
    $display("test interrupts done");
  endtask : test_interrupts

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    fail_count          = 0;
    comparisons         = 0;
    tick_cnt            = 3'h0;
    lirc_tick           = 1'b0;
    resetn              = 1'b0;
    bus_req             = '0;
    low_voltage_detect  = 1'b0;
    power_down          = 1'b0;
    watchdog_timeout    = 1'b0;
    watchdog_ctrl_fault = 1'b0;
    halt_entry          = 1'b0;
    watchdog_clear      = 1'b0;
    repeat (2) @(posedge clock);
    test_power_on();
    test_valid_codes();
    test_bad_code();
    test_low_voltage();
    test_watchdog();
    test_interrupts();
    conclude();
  end

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    conclude();
  end
endmodule : low_voltage_reset_flag_top_tb

// >>> rtl/low_voltage_reset_flag_pkg.sv
// constants, types and register map of the low-voltage reset and reset flag block
// assumes a single 50 MHz clock and a low-speed oscillator tick synchronous to it
package low_voltage_reset_flag_pkg;

  localparam int          ADDR_W          = 3;
  localparam int          DATA_W          = 8;

  // register offsets
  localparam logic [2:0]  OFF_LEVEL_SEL   = 3'h0;
  localparam logic [2:0]  OFF_CTRL        = 3'h1;
  localparam logic [2:0]  OFF_STATUS      = 3'h2;
  localparam logic [2:0]  OFF_IRQ_STATUS  = 3'h3;
  localparam logic [2:0]  OFF_IRQ_MASK    = 3'h4;

  // level select codes
  localparam logic [7:0]  LEVEL_2V10      = 8'h55;
  localparam logic [7:0]  LEVEL_2V55      = 8'h33;
  localparam logic [7:0]  LEVEL_3V15      = 8'h99;
  localparam logic [7:0]  LEVEL_3V80      = 8'hAA;
  localparam logic [7:0]  LEVEL_POR       = LEVEL_2V10;

  // control register fields
  localparam int          CTRL_KEEPALIVE  = 7;
  localparam int          CTRL_LVR_FLAG   = 2;
  localparam int          CTRL_CODE_FLAG  = 1;
  localparam int          CTRL_WDC_FLAG   = 0;
  localparam logic [7:0]  CTRL_IMPL_MASK  = 8'h87;
  localparam logic [7:0]  CTRL_POR        = 8'h00;

  // status flags
  localparam int          STAT_TIMEOUT    = 1;
  localparam int          STAT_POWERDOWN  = 0;
  localparam logic [1:0]  STAT_POR        = 2'h0;

  // interrupt status / mask layout
  localparam int          IRQ_W           = 4;
  localparam int          IRQ_LVR         = 0;
  localparam int          IRQ_CODE        = 1;
  localparam int          IRQ_WDT         = 2;
  localparam int          IRQ_WDC         = 3;
  localparam logic [3:0]  IRQ_POR         = 4'h0;

  // reset issue delay in low-speed oscillator cycles: fires on the third tick,
  // so the delay lands between two and three full cycles
  localparam int          DELAY_LIRC_MIN  = 2;
  localparam logic [1:0]  DELAY_TICKS     = 2'(DELAY_LIRC_MIN + 1);

  typedef enum logic [1:0] {
    LOW_VOLTAGE_RESET_FLAG_CAUSE_NONE,
    LOW_VOLTAGE_RESET_FLAG_CAUSE_LVR,
    LOW_VOLTAGE_RESET_FLAG_CAUSE_CODE,
    LOW_VOLTAGE_RESET_FLAG_CAUSE_WDT
  } low_voltage_reset_flag_cause_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [2:0]        addr;
    logic [7:0]        wdata;
  } low_voltage_reset_flag_bus_req_t;

  typedef struct packed {
    logic pc_zero;
    logic sp_top;
    logic int_disable;
    logic wdt_tb_clear;
    logic timers_off;
    logic ports_input;
  } low_voltage_reset_flag_por_fx_t;

  localparam low_voltage_reset_flag_por_fx_t POR_FX_ALL  = 6'h3F;
  localparam low_voltage_reset_flag_por_fx_t POR_FX_NONE = 6'h00;

endpackage : low_voltage_reset_flag_pkg

// >>> rtl/low_voltage_reset_flag_top.sv
// low-voltage reset level select, reset cause flags and watchdog reset effects
// assumes: resetn is the power-on reset; lirc_tick is a one-cycle pulse per
// low-speed oscillator cycle; power_down is high in sleep or idle mode
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/100ps

module low_voltage_reset_flag_top (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire low_voltage_reset_flag_pkg::low_voltage_reset_flag_bus_req_t bus_req,
  output logic [7:0]                 bus_rdata,
  input  wire logic                  lirc_tick,
  input  wire logic                  low_voltage_detect,
  input  wire logic                  power_down,
  input  wire logic                  watchdog_timeout,
  input  wire logic                  watchdog_ctrl_fault,
  input  wire logic                  halt_entry,
  input  wire logic                  watchdog_clear,
  output logic                       chip_reset,
  output logic                       pc_sp_clear,
  output low_voltage_reset_flag_pkg::low_voltage_reset_flag_por_fx_t     por_effects,
  output logic                       watchdog_run,
  output logic                       idle_sysclk_keepalive,
  output logic [7:0]                 level_code,
  output logic                       irq
);

  typedef enum logic [1:0] {
    LOW_VOLTAGE_RESET_FLAG_ST_IDLE,
    LOW_VOLTAGE_RESET_FLAG_ST_WAIT,
    LOW_VOLTAGE_RESET_FLAG_ST_FIRE
  } low_voltage_reset_flag_state_t;

  low_voltage_reset_flag_state_t          state_r;
  low_voltage_reset_flag_pkg::low_voltage_reset_flag_cause_t cause_r;
  logic [1:0]           tick_cnt_r;
  logic [7:0]           level_r;
  logic [7:0]           ctrl_r;
  logic [7:0]           ctrl_nxt;
  logic [1:0]           stat_r;
  logic [1:0]           stat_nxt;
  logic [3:0]           irq_st_r;
  logic [3:0]           irq_st_nxt;
  logic [3:0]           irq_mask_r;
  logic [3:0]           irq_ev;
  logic                 lvd_meta_r;
  logic                 lvd_sync_r;
  logic                 lvd_q_r;
  logic                 code_ok;
  logic                 wr_level;
  logic                 wr_ctrl;
  logic                 wr_irq_st;
  logic                 wr_irq_mask;
  logic                 fire_now;
  logic                 fire_lvr;
  logic                 fire_code;
  logic                 fire_wdt;
  logic                 wdt_sleep;
  logic                 por_hold_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign wr_level    = bus_req.wr && (bus_req.addr == low_voltage_reset_flag_pkg::OFF_LEVEL_SEL);
  assign wr_ctrl     = bus_req.wr && (bus_req.addr == low_voltage_reset_flag_pkg::OFF_CTRL);
  assign wr_irq_st   = bus_req.wr && (bus_req.addr == low_voltage_reset_flag_pkg::OFF_IRQ_STATUS);
  assign wr_irq_mask = bus_req.wr && (bus_req.addr == low_voltage_reset_flag_pkg::OFF_IRQ_MASK);

  always_comb begin
    code_ok = (level_r == low_voltage_reset_flag_pkg::LEVEL_2V10) ||
              (level_r == low_voltage_reset_flag_pkg::LEVEL_2V55) ||
              (level_r == low_voltage_reset_flag_pkg::LEVEL_3V15) ||
              (level_r == low_voltage_reset_flag_pkg::LEVEL_3V80);
  end

  ////////////////////////////////////////////////////////////////////////////
  // low-voltage detect synchroniser, then sampled on the slow tick

  always_ff @(posedge clock) begin
    if (!resetn) begin
      lvd_meta_r <= 1'b0;
      lvd_sync_r <= 1'b0;
      lvd_q_r    <= 1'b0;
    end else begin
      lvd_meta_r <= low_voltage_detect;
      lvd_sync_r <= lvd_meta_r;
      if (lirc_tick) begin
        lvd_q_r <= lvd_sync_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset issue sequencer

  assign fire_now  = (state_r == LOW_VOLTAGE_RESET_FLAG_ST_WAIT) && lirc_tick &&
                     (tick_cnt_r == low_voltage_reset_flag_pkg::DELAY_TICKS - 2'h1);
  assign fire_lvr  = fire_now && (cause_r == low_voltage_reset_flag_pkg::LOW_VOLTAGE_RESET_FLAG_CAUSE_LVR);
  assign fire_code = fire_now && (cause_r == low_voltage_reset_flag_pkg::LOW_VOLTAGE_RESET_FLAG_CAUSE_CODE);
  assign fire_wdt  = fire_now && (cause_r == low_voltage_reset_flag_pkg::LOW_VOLTAGE_RESET_FLAG_CAUSE_WDT);
  assign wdt_sleep = watchdog_timeout && power_down;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r    <= LOW_VOLTAGE_RESET_FLAG_ST_IDLE;
      cause_r    <= low_voltage_reset_flag_pkg::LOW_VOLTAGE_RESET_FLAG_CAUSE_NONE;
      tick_cnt_r <= 2'h0;
    end else begin
      case (state_r)
        LOW_VOLTAGE_RESET_FLAG_ST_IDLE: begin
          tick_cnt_r <= 2'h0;
          if (!code_ok) begin
            state_r <= LOW_VOLTAGE_RESET_FLAG_ST_WAIT;
            cause_r <= low_voltage_reset_flag_pkg::LOW_VOLTAGE_RESET_FLAG_CAUSE_CODE;
          end else if (lvd_q_r && !power_down) begin
            state_r <= LOW_VOLTAGE_RESET_FLAG_ST_WAIT;
            cause_r <= low_voltage_reset_flag_pkg::LOW_VOLTAGE_RESET_FLAG_CAUSE_LVR;
          end else if (watchdog_timeout && !power_down) begin
            state_r <= LOW_VOLTAGE_RESET_FLAG_ST_WAIT;
            cause_r <= low_voltage_reset_flag_pkg::LOW_VOLTAGE_RESET_FLAG_CAUSE_WDT;
          end
        end
        LOW_VOLTAGE_RESET_FLAG_ST_WAIT: begin
          if (lirc_tick) begin
            tick_cnt_r <= tick_cnt_r + 2'h1;
          end
          if (fire_now) begin
            state_r <= LOW_VOLTAGE_RESET_FLAG_ST_FIRE;
          end
        end
        LOW_VOLTAGE_RESET_FLAG_ST_FIRE: begin
          // a low-voltage reset is held while the supply stays low and power_down is low
          if (cause_r != low_voltage_reset_flag_pkg::LOW_VOLTAGE_RESET_FLAG_CAUSE_LVR || !lvd_q_r || power_down) begin
            state_r <= LOW_VOLTAGE_RESET_FLAG_ST_IDLE;
            cause_r <= low_voltage_reset_flag_pkg::LOW_VOLTAGE_RESET_FLAG_CAUSE_NONE;
          end
        end
        default: begin
          state_r <= LOW_VOLTAGE_RESET_FLAG_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level select register

  always_ff @(posedge clock) begin
    if (!resetn) begin
      level_r <= low_voltage_reset_flag_pkg::LEVEL_POR;
    end else if (fire_code) begin
      level_r <= low_voltage_reset_flag_pkg::LEVEL_POR;
    end else if (wr_level) begin
      level_r <= bus_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: flags are set by hardware, cleared only by writing zero

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt[low_voltage_reset_flag_pkg::CTRL_KEEPALIVE] = bus_req.wdata[low_voltage_reset_flag_pkg::CTRL_KEEPALIVE];
      ctrl_nxt[low_voltage_reset_flag_pkg::CTRL_LVR_FLAG]  = ctrl_r[low_voltage_reset_flag_pkg::CTRL_LVR_FLAG] &
                                           bus_req.wdata[low_voltage_reset_flag_pkg::CTRL_LVR_FLAG];
      ctrl_nxt[low_voltage_reset_flag_pkg::CTRL_CODE_FLAG] = ctrl_r[low_voltage_reset_flag_pkg::CTRL_CODE_FLAG] &
                                           bus_req.wdata[low_voltage_reset_flag_pkg::CTRL_CODE_FLAG];
      ctrl_nxt[low_voltage_reset_flag_pkg::CTRL_WDC_FLAG]  = ctrl_r[low_voltage_reset_flag_pkg::CTRL_WDC_FLAG] &
                                           bus_req.wdata[low_voltage_reset_flag_pkg::CTRL_WDC_FLAG];
    end
    if (fire_lvr) begin
      ctrl_nxt[low_voltage_reset_flag_pkg::CTRL_LVR_FLAG] = 1'b1;
    end
    if (fire_code) begin
      ctrl_nxt[low_voltage_reset_flag_pkg::CTRL_CODE_FLAG] = 1'b1;
    end
    if (watchdog_ctrl_fault) begin
      ctrl_nxt[low_voltage_reset_flag_pkg::CTRL_WDC_FLAG] = 1'b1;
    end
    ctrl_nxt = ctrl_nxt & low_voltage_reset_flag_pkg::CTRL_IMPL_MASK;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl_r <= low_voltage_reset_flag_pkg::CTRL_POR;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeout and power-down flags

  always_comb begin
    stat_nxt = stat_r;
    if (watchdog_clear) begin
      stat_nxt = 2'h0;
    end
    if (halt_entry) begin
      stat_nxt[low_voltage_reset_flag_pkg::STAT_TIMEOUT]   = 1'b0;
      stat_nxt[low_voltage_reset_flag_pkg::STAT_POWERDOWN] = 1'b1;
    end
    if (fire_wdt) begin
      stat_nxt[low_voltage_reset_flag_pkg::STAT_TIMEOUT] = 1'b1;
    end
    if (wdt_sleep) begin
      stat_nxt[low_voltage_reset_flag_pkg::STAT_TIMEOUT]   = 1'b1;
      stat_nxt[low_voltage_reset_flag_pkg::STAT_POWERDOWN] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      stat_r <= low_voltage_reset_flag_pkg::STAT_POR;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  always_comb begin
    irq_ev                     = 4'h0;
    irq_ev[low_voltage_reset_flag_pkg::IRQ_LVR]  = fire_lvr;
    irq_ev[low_voltage_reset_flag_pkg::IRQ_CODE] = fire_code;
    irq_ev[low_voltage_reset_flag_pkg::IRQ_WDT]  = fire_wdt || wdt_sleep;
    irq_ev[low_voltage_reset_flag_pkg::IRQ_WDC]  = watchdog_ctrl_fault;
    irq_st_nxt                 = irq_st_r;
    if (wr_irq_st) begin
      irq_st_nxt = irq_st_r & ~bus_req.wdata[3:0];
    end
    irq_st_nxt = irq_st_nxt | irq_ev;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_st_r   <= low_voltage_reset_flag_pkg::IRQ_POR;
      irq_mask_r <= low_voltage_reset_flag_pkg::IRQ_POR;
      irq        <= 1'b0;
    end else begin
      irq_st_r <= irq_st_nxt;
      if (wr_irq_mask) begin
        irq_mask_r <= bus_req.wdata[3:0];
      end
      irq <= |(irq_st_nxt & (wr_irq_mask ? bus_req.wdata[3:0] : irq_mask_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data valid the cycle after the strobe only

  always_ff @(posedge clock) begin
    if (!resetn) begin
      bus_rdata <= 8'h00;
    end else if (!bus_req.rd) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.addr == low_voltage_reset_flag_pkg::OFF_LEVEL_SEL) begin
      bus_rdata <= level_r;
    end else if (bus_req.addr == low_voltage_reset_flag_pkg::OFF_CTRL) begin
      bus_rdata <= ctrl_r & low_voltage_reset_flag_pkg::CTRL_IMPL_MASK;
    end else if (bus_req.addr == low_voltage_reset_flag_pkg::OFF_STATUS) begin
      bus_rdata <= {6'h00, stat_r};
    end else if (bus_req.addr == low_voltage_reset_flag_pkg::OFF_IRQ_STATUS) begin
      bus_rdata <= {4'h0, irq_st_r};
    end else if (bus_req.addr == low_voltage_reset_flag_pkg::OFF_IRQ_MASK) begin
      bus_rdata <= {4'h0, irq_mask_r};
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset outputs and power-on effects

  always_ff @(posedge clock) begin
    if (!resetn) begin
      chip_reset  <= 1'b0;
      pc_sp_clear <= 1'b0;
    end else begin
      chip_reset  <= (state_r == LOW_VOLTAGE_RESET_FLAG_ST_FIRE);
      pc_sp_clear <= wdt_sleep;
    end
  end

  // power-on effects stand through reset and one cycle after release
  always_ff @(posedge clock) begin
    if (!resetn) begin
      por_hold_r   <= 1'b1;
      por_effects  <= low_voltage_reset_flag_pkg::POR_FX_ALL;
      watchdog_run <= 1'b0;
    end else begin
      por_hold_r   <= 1'b0;
      por_effects  <= low_voltage_reset_flag_pkg::POR_FX_NONE;
      watchdog_run <= !por_hold_r || watchdog_run;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      idle_sysclk_keepalive <= 1'b0;
      level_code            <= low_voltage_reset_flag_pkg::LEVEL_POR;
    end else begin
      idle_sysclk_keepalive <= ctrl_nxt[low_voltage_reset_flag_pkg::CTRL_KEEPALIVE];
      level_code            <= level_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_por_level: assert property (@(posedge clock) disable iff (!resetn)
    $rose(resetn) |-> level_r == low_voltage_reset_flag_pkg::LEVEL_POR)
    else $error("level select not at power-on value");

  a_bad_code: assert property (@(posedge clock) disable iff (!resetn)
    (state_r == LOW_VOLTAGE_RESET_FLAG_ST_IDLE && !code_ok) |=> state_r == LOW_VOLTAGE_RESET_FLAG_ST_WAIT &&
      cause_r == low_voltage_reset_flag_pkg::LOW_VOLTAGE_RESET_FLAG_CAUSE_CODE)
    else $error("invalid code not acted on");

  a_delay_fire: assert property (@(posedge clock) disable iff (!resetn)
    (state_r == LOW_VOLTAGE_RESET_FLAG_ST_WAIT && lirc_tick && tick_cnt_r == 2'h2)
      |=> state_r == LOW_VOLTAGE_RESET_FLAG_ST_FIRE ##1 chip_reset)
    else $error("reset not issued on third tick");

  a_lvr_keeps: assert property (@(posedge clock) disable iff (!resetn)
    (fire_lvr && !bus_req.wr) |=> $stable(level_r))
    else $error("level select changed by low-voltage reset");

  a_code_restore: assert property (@(posedge clock) disable iff (!resetn)
    fire_code |=> level_r == low_voltage_reset_flag_pkg::LEVEL_POR && ctrl_r[low_voltage_reset_flag_pkg::CTRL_CODE_FLAG])
    else $error("bad code not restored or flagged");

  a_lvr_flag: assert property (@(posedge clock) disable iff (!resetn)
    fire_lvr |=> ctrl_r[low_voltage_reset_flag_pkg::CTRL_LVR_FLAG] ##1 chip_reset)
    else $error("low-voltage flag not set");

  a_flag_sticky: assert property (@(posedge clock) disable iff (!resetn)
    (ctrl_r[low_voltage_reset_flag_pkg::CTRL_CODE_FLAG] && !wr_ctrl) |=> ctrl_r[low_voltage_reset_flag_pkg::CTRL_CODE_FLAG])
    else $error("fault flag cleared without write");

  a_unimpl_zero: assert property (@(posedge clock) disable iff (!resetn)
    (bus_req.rd && bus_req.addr == low_voltage_reset_flag_pkg::OFF_CTRL) |=> bus_rdata[6:3] == 4'h0)
    else $error("unimplemented control bits read nonzero");

  a_wdt_normal: assert property (@(posedge clock) disable iff (!resetn)
    (fire_wdt && !wdt_sleep && !halt_entry && !watchdog_clear) |=>
      stat_r[low_voltage_reset_flag_pkg::STAT_TIMEOUT] &&
      stat_r[low_voltage_reset_flag_pkg::STAT_POWERDOWN] == $past(stat_r[low_voltage_reset_flag_pkg::STAT_POWERDOWN]))
    else $error("normal watchdog reset flags wrong");

  a_wdt_sleep: assert property (@(posedge clock) disable iff (!resetn)
    wdt_sleep |=> pc_sp_clear && stat_r == 2'h3 && !chip_reset)
    else $error("sleep watchdog timeout handled wrongly");

  a_por_flags: assert property (@(posedge clock) disable iff (!resetn)
    $rose(resetn) |-> stat_r == low_voltage_reset_flag_pkg::STAT_POR)
    else $error("power-on flags not cleared");

  a_por_fx: assert property (@(posedge clock) disable iff (!resetn)
    $rose(resetn) |-> por_effects == low_voltage_reset_flag_pkg::POR_FX_ALL ##1
      por_effects == low_voltage_reset_flag_pkg::POR_FX_NONE ##1 watchdog_run)
    else $error("power-on effects sequence wrong");

  a_pd_no_lvr: assert property (@(posedge clock) disable iff (!resetn)
    (state_r == LOW_VOLTAGE_RESET_FLAG_ST_IDLE && power_down && code_ok) |=> state_r == LOW_VOLTAGE_RESET_FLAG_ST_IDLE)
    else $error("low-voltage reset armed in power-down");

endmodule : low_voltage_reset_flag_top
